// ==== verilog/hotplug_slot_pkg.sv ====
// constants and types for the hot-plug slot event/indicator block
// assumes a 33 or 66 MHz bus clock picked by the fast bus select pin
package hotplug_slot_pkg;

  localparam int unsigned NUM_SLOTS = 4;

  // ----------------------------------------------------------------
  // register offsets, one per slot
  // ----------------------------------------------------------------
  localparam logic [4:0] IND_OFS  [NUM_SLOTS] =
    '{5'h03, 5'h0b, 5'h13, 5'h1b};
  localparam logic [4:0] STAT_OFS [NUM_SLOTS] =
    '{5'h06, 5'h0e, 5'h16, 5'h1e};
  localparam logic [4:0] EN_OFS   [NUM_SLOTS] =
    '{5'h07, 5'h0f, 5'h17, 5'h1f};

  localparam logic [7:0] REG_RESET   = 8'h00;
  localparam logic [7:0] IND_RW_MASK = 8'h0f;
  localparam logic [7:0] EVT_RW_MASK = 8'h7f;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned IND_A_LSB = 0;
  localparam int unsigned IND_B_LSB = 2;
  localparam int unsigned ST_BUS    = 6;
  localparam int unsigned ST_GOOD   = 5;
  localparam int unsigned ST_FAULT  = 4;

  // ----------------------------------------------------------------
  // blink timing
  // ----------------------------------------------------------------
  localparam int unsigned BUS_HZ_NORM  = 33_000_000;
  localparam int unsigned BUS_HZ_FAST  = 66_000_000;
  localparam int unsigned BLINK_QTR_MS = 250;
  localparam int unsigned QTR_CYC_NORM_DEF =
    BUS_HZ_NORM / 1000 * BLINK_QTR_MS;
  localparam int unsigned QTR_CYC_FAST_DEF =
    BUS_HZ_FAST / 1000 * BLINK_QTR_MS;
  localparam int unsigned CNT_W = 25;

  typedef enum logic [1:0] {
    IND_LOW  = 2'b00,
    IND_SLOW = 2'b01,
    IND_FAST = 2'b10,
    IND_HIGH = 2'b11
  } ind_mode_t;

  // sense pins of one slot, ordered as status bits 5..0
  typedef struct packed {
    logic supply_ok;
    logic supply_fault;
    logic mech_b;
    logic mech_a;
    logic card_b;
    logic card_a;
  } slot_sense_t;

endpackage

// ==== verilog/hotplug_slot_event_indicator.sv ====
// per-slot attention indicators and event status/enable, four slots
// assumes a simple parallel register port on the bus clock; sense
// pins are asynchronous, bus switch level comes from same-clock logic
//
// Functional notes
// - indicator bits 7..4 and event register bit 7 always read zero.
// - bits 3..2 pick indicator b: low, slow blink, fast blink, high.
// - bits 1..0 pick indicator a with the same coding.
// - blink timing counts bus clocks, divider picked by fast select.
// - indicator registers at 03,0b,13,1b; all registers reset to 00.
// - event status registers at 06,0e,16,1e.
// - event enable registers at 07,0f,17,1f.
// - status bits stay set until software writes one to them.
// - bit 6 sets on any bus switch control level change.
// - bit 5 sets on either edge of supply ok.
// - bit 4 sets when supply fault asserts, not on release.
// - bit 3 sets on mechanical sense b change.
// - bit 2 sets on mechanical sense a change.
// - bit 1 sets on card present b change.
// - bit 0 sets on card present a change.
// - enable bits gate status onto interrupt; status records anyway.
// - enabled bus switch change signals the interrupt.
`timescale 1ns/1ps
`default_nettype none

module hotplug_slot_event_indicator #(
  parameter int unsigned QTR_CYC_NORM =
    hotplug_slot_pkg::QTR_CYC_NORM_DEF,
  parameter int unsigned QTR_CYC_FAST =
    hotplug_slot_pkg::QTR_CYC_FAST_DEF
) (
  input  wire logic                              clk,
  input  wire logic                              rstn,
  input  wire logic [4:0]                        reg_addr,
  input  wire logic                              reg_wr,
  input  wire logic                              reg_rd,
  input  wire logic [7:0]                        reg_wdata,
  output var  logic [7:0]                        reg_rdata,
  input  wire logic                              fast_bus_select,
  input  wire logic [3:0]                        bus_switch_ctl_out,
  input  wire hotplug_slot_pkg::slot_sense_t [3:0] sense_in,
  output var  logic [3:0]                        indicator_a_out,
  output var  logic [3:0]                        indicator_b_out,
  output var  logic                              slot_irq_n_o,
  output var  logic                              slot_irq_n_oe
);
  import hotplug_slot_pkg::*;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic       rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------------------------------
  // pin synchronisers and change detect
  // ----------------------------------------------------------------
  slot_sense_t [3:0] sense_s1_r;
  slot_sense_t [3:0] sense_s2_r;
  slot_sense_t [3:0] sense_prev_r;
  logic [3:0]        bus_prev_r;
  logic              fast_s1_r;
  logic              fast_s2_r;
  logic [2:0]        fill_r;
  logic              primed_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_s1_r   <= '0;
      sense_s2_r   <= '0;
      sense_prev_r <= '0;
      bus_prev_r   <= 4'h0;
      fast_s1_r    <= 1'b0;
      fast_s2_r    <= 1'b0;
      fill_r       <= 3'h0;
    end else begin
      sense_s1_r   <= sense_in;
      sense_s2_r   <= sense_s1_r;
      sense_prev_r <= sense_s2_r;
      bus_prev_r   <= bus_switch_ctl_out;
      fast_s1_r    <= fast_bus_select;
      fast_s2_r    <= fast_s1_r;
      fill_r       <= {fill_r[1:0], 1'b1};
    end
  end
  // no events until the pipeline holds real samples
  assign primed_r = fill_r[2];

  logic [3:0][6:0] evt;

  always_comb begin
    for (int s = 0; s < 4; s++) begin
      // bits 3..0 and 5: any level change
      evt[s][5:0] = sense_s2_r[s] ^ sense_prev_r[s];
      evt[s][ST_FAULT] = sense_s2_r[s].supply_fault &
                         ~sense_prev_r[s].supply_fault;
      evt[s][ST_BUS] = bus_switch_ctl_out[s] ^ bus_prev_r[s];
      if (!primed_r) begin
        evt[s] = 7'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  logic [3:0] ind_hit;
  logic [3:0] stat_hit;
  logic [3:0] en_hit;

  always_comb begin
    for (int s = 0; s < 4; s++) begin
      ind_hit[s]  = reg_addr == IND_OFS[s];
      stat_hit[s] = reg_addr == STAT_OFS[s];
      en_hit[s]   = reg_addr == EN_OFS[s];
    end
  end

  logic [3:0][7:0] ind_r;
  logic [3:0][7:0] stat_r;
  logic [3:0][7:0] en_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_r <= {4{REG_RESET}};
    end else begin
      for (int s = 0; s < 4; s++) begin
        if (reg_wr && ind_hit[s]) begin
          ind_r[s] <= reg_wdata & IND_RW_MASK;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= {4{REG_RESET}};
    end else begin
      for (int s = 0; s < 4; s++) begin
        if (reg_wr && en_hit[s]) begin
          en_r[s] <= reg_wdata & EVT_RW_MASK;
        end
      end
    end
  end

  // write one clears; a new event in the same cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_r <= {4{REG_RESET}};
    end else begin
      for (int s = 0; s < 4; s++) begin
        stat_r[s] <= ((stat_r[s] &
                      ~((reg_wr && stat_hit[s]) ? reg_wdata : 8'h00)) |
                      {1'b0, evt[s]}) & EVT_RW_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // read path, one cycle after the read strobe
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    for (int s = 0; s < 4; s++) begin
      if (ind_hit[s]) begin
        rd_mux = ind_r[s];
      end
      if (stat_hit[s]) begin
        rd_mux = stat_r[s];
      end
      if (en_hit[s]) begin
        rd_mux = en_r[s];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // blink time base: quarter-second ticks
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] lim_w;
  logic             qtr_tick_r;
  logic [1:0]       phase_r;

  assign lim_w = fast_s2_r ? CNT_W'(QTR_CYC_FAST - 1)
                           : CNT_W'(QTR_CYC_NORM - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r      <= '0;
      qtr_tick_r <= 1'b0;
    end else if (cnt_r >= lim_w) begin
      cnt_r      <= '0;
      qtr_tick_r <= 1'b1;
    end else begin
      cnt_r      <= cnt_r + 1'b1;
      qtr_tick_r <= 1'b0;
    end
  end

  // phase[0] flips each quarter second, phase[1] each half
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= 2'b00;
    end else if (qtr_tick_r) begin
      phase_r <= phase_r + 2'b01;
    end
  end

  function automatic logic mode_level(input logic [1:0] m,
                                      input logic [1:0] ph);
    logic lvl;
    case (ind_mode_t'(m))
      IND_LOW:  lvl = 1'b0;
      IND_SLOW: lvl = ph[1];
      IND_FAST: lvl = ph[0];
      IND_HIGH: lvl = 1'b1;
      default:  lvl = 1'b0;
    endcase
    return lvl;
  endfunction

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      indicator_a_out <= 4'h0;
      indicator_b_out <= 4'h0;
    end else begin
      for (int s = 0; s < 4; s++) begin
        indicator_a_out[s] <=
          mode_level(ind_r[s][IND_A_LSB +: 2], phase_r);
        indicator_b_out[s] <=
          mode_level(ind_r[s][IND_B_LSB +: 2], phase_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // open-drain interrupt
  // ----------------------------------------------------------------
  logic any_req;

  assign any_req = |(stat_r & en_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_irq_n_oe <= 1'b0;
      slot_irq_n_o  <= 1'b0;
    end else begin
      slot_irq_n_oe <= any_req;
      slot_irq_n_o  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_rsvd_read_zero: assert property (
    reg_rd && (ind_hit[0] || stat_hit[1] || en_hit[2])
    |=> reg_rdata[7] == 1'b0 && (!$past(ind_hit[0]) ||
        reg_rdata[7:4] == 4'h0))
    else $error("reserved bits read nonzero");

  chk_ind_b_level: assert property (
    $stable(ind_r[1]) && ind_r[1][3] == ind_r[1][2]
    |-> indicator_b_out[1] == ind_r[1][3])
    else $error("indicator b wrong steady level");

  chk_ind_a_blink: assert property (
    $stable(ind_r[1]) && ind_r[1][1:0] == 2'b01
    |-> indicator_a_out[1] == $past(phase_r[1]))
    else $error("indicator a slow blink off phase");

  chk_tick_spacing: assert property (
    qtr_tick_r |-> $past(cnt_r) >= $past(lim_w) &&
    cnt_r == '0)
    else $error("quarter tick at wrong count");

  chk_w1c_clear: assert property (
    reg_wr && stat_hit[0] && reg_wdata[0] && !evt[0][0]
    |=> !stat_r[0][0])
    else $error("status bit not cleared by write one");

  chk_status_hold: assert property (
    stat_r[2][3] && !(reg_wr && stat_hit[2] && reg_wdata[3])
    |=> stat_r[2][3])
    else $error("status bit lost without clear");

  chk_fault_rise: assert property (
    primed_r && $rose(sense_s2_r[0].supply_fault)
    |=> stat_r[0][ST_FAULT])
    else $error("fault assert not recorded");

  chk_fault_fall: assert property (
    $fell(sense_s2_r[0].supply_fault) && !stat_r[0][ST_FAULT]
    |=> !stat_r[0][ST_FAULT])
    else $error("fault release set status");

  chk_good_edge: assert property (
    primed_r && $changed(sense_s2_r[3].supply_ok)
    |=> stat_r[3][ST_GOOD])
    else $error("supply ok change not recorded");

  chk_bus_irq: assert property (
    primed_r && en_r[0][ST_BUS] && $changed(bus_switch_ctl_out[0])
    && !(reg_wr && (en_hit[0] || stat_hit[0]))
    |-> ##[1:2] slot_irq_n_oe)
    else $error("bus switch change gave no interrupt");

  chk_irq_gate: assert property (
    slot_irq_n_oe == $past(any_req) && !slot_irq_n_o)
    else $error("interrupt drive not matching enabled status");

  chk_sync_depth: assert property (
    primed_r |-> sense_s2_r == $past(sense_in, 2))
    else $error("sense pins not two-stage synchronised");

  cov_slow_blink: cover property (
    ind_r[1][1:0] == 2'b01 && $rose(indicator_a_out[1]));
  cov_fault_irq: cover property (
    slot_irq_n_oe && stat_r[0][ST_FAULT]);
  cov_w1c_clear: cover property (
    reg_wr && stat_hit[1] && stat_r[1] != 8'h00);

endmodule

`default_nettype wire

// ==== verification/slot_partner.sv ====
// slot-side model: sense pins, bus switch level and indicator leds
// assumes the bench calls its tasks; pins change at falling edges
`timescale 1ns/1ps
`default_nettype none

module slot_partner (
  input  wire logic                              clk,
  input  wire logic [3:0]                        led_a,
  input  wire logic [3:0]                        led_b,
  output var  hotplug_slot_pkg::slot_sense_t [3:0] sense,
  output var  logic [3:0]                        bus_sw
);
  import hotplug_slot_pkg::*;

  initial begin
    sense  = '0;
    bus_sw = '0;
  end

  // --------------------------------------------------------------
  // pin stimulus; index 6 is the bus switch level
  // --------------------------------------------------------------
  task automatic flip(input int s, input int b);
    @(negedge clk);
    if (b == ST_BUS) bus_sw[s] = ~bus_sw[s];
    else sense[s][b] = ~sense[s][b];
  endtask

  // --------------------------------------------------------------
  // led watch: high samples and level changes over n cycles
  // --------------------------------------------------------------
  task automatic measure(input int s, input int n, output int ha,
                         output int ea, output int hb, output int eb);
    logic pa;
    logic pb;
    ha = 0;
    ea = 0;
    hb = 0;
    eb = 0;
    @(negedge clk);
    pa = led_a[s];
    pb = led_b[s];
    repeat (n) begin
      @(negedge clk);
      if (led_a[s] === 1'b1) ha++;
      if (led_b[s] === 1'b1) hb++;
      if (led_a[s] !== pa) ea++;
      if (led_b[s] !== pb) eb++;
      pa = led_a[s];
      pb = led_b[s];
    end
  endtask
endmodule

`default_nettype wire

// ==== verification/tb_hotplug_slot_event_indicator.sv ====
// bench for the slot event and indicator block
// assumes short quarter-second counts; pull-up on the interrupt line
`timescale 1ns/1ps
`default_nettype none

module tb_hotplug_slot_event_indicator;
  import hotplug_slot_pkg::*;
  localparam int QN = 8;
  localparam int QF = 16;
  logic              clk;
  logic              rstn;
  logic [4:0]        reg_addr;
  logic              reg_wr;
  logic              reg_rd;
  logic [7:0]        reg_wdata;
  logic [7:0]        reg_rdata;
  logic              fast_sel;
  logic [3:0]        bus_sw;
  slot_sense_t [3:0] sense;
  logic [3:0]        led_a;
  logic [3:0]        led_b;
  logic              irq_o;
  logic              irq_oe;
  wire               irq_line;
  int                num_errors;
  int                n_compared;

  assign irq_line = irq_oe ? irq_o : 1'b1;

  hotplug_slot_event_indicator #(
    .QTR_CYC_NORM(QN),
    .QTR_CYC_FAST(QF)
  ) hotplug_slot_event_indicator_inst (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fast_bus_select(fast_sel), .bus_switch_ctl_out(bus_sw),
    .sense_in(sense), .indicator_a_out(led_a),
    .indicator_b_out(led_b), .slot_irq_n_o(irq_o),
    .slot_irq_n_oe(irq_oe)
  );

  slot_partner slot_partner_inst (
    .clk(clk), .led_a(led_a), .led_b(led_b), .sense(sense),
    .bus_sw(bus_sw)
  );

  // --------------------------------------------------------------
  // compare, report and register tasks
  // --------------------------------------------------------------
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t reg got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t irq line got %b want %b", $time, got, exp);
    end
  endtask

  task automatic chkn(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %0t led count got %0d want %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk8(reg_rdata, exp);
  endtask

  function automatic int exp_hi(input int m, input int q);
    return (m == 0) ? 0 : (m == 3) ? 8 * q : 4 * q;
  endfunction

  function automatic int exp_ed(input int m);
    return (m == 1) ? 4 : (m == 2) ? 8 : 0;
  endfunction

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    for (int s = 0; s < NUM_SLOTS; s++) begin
      rd_chk(IND_OFS[s], 8'h00);
      rd_chk(STAT_OFS[s], 8'h00);
      rd_chk(EN_OFS[s], 8'h00);
      wr(IND_OFS[s], 8'hff);
      rd_chk(IND_OFS[s], 8'h0f);
      wr(EN_OFS[s], 8'hff);
      rd_chk(EN_OFS[s], 8'h7f);
      wr(STAT_OFS[s], 8'hff);
      rd_chk(STAT_OFS[s], 8'h00);
      wr(IND_OFS[s], 8'h00);
      wr(EN_OFS[s], 8'h00);
    end
    wr(5'h00, 8'hff);
    rd_chk(5'h00, 8'h00);
  endtask

  task automatic t_ind();
    int q;
    int ha;
    int ea;
    int hb;
    int eb;
    for (int sp = 0; sp < 2; sp++) begin
      fast_sel = sp[0];
      q = sp ? QF : QN;
      repeat (300) @(negedge clk);
      for (int m = 0; m < 4; m++) begin
        wr(IND_OFS[m], 8'((3 - m) << 2 | m));
        repeat (4) @(negedge clk);
        slot_partner_inst.measure(m, 8 * q, ha, ea, hb, eb);
        chkn(ha, exp_hi(m, q));
        chkn(ea, exp_ed(m));
        chkn(hb, exp_hi(3 - m, q));
        chkn(eb, exp_ed(3 - m));
        wr(IND_OFS[m], 8'h00);
      end
    end
  endtask

  task automatic t_evt(input int s);
    logic [7:0] bit_v;
    wr(EN_OFS[s], 8'h7f);
    for (int b = 0; b < 7; b++) begin
      bit_v = 8'h01 << b;
      slot_partner_inst.flip(s, b);
      repeat (6) @(negedge clk);
      rd_chk(STAT_OFS[s], bit_v);
      chk1(irq_line, 1'b0);
      wr(STAT_OFS[s], 8'h00);
      rd_chk(STAT_OFS[s], bit_v);
      wr(STAT_OFS[s], bit_v);
      repeat (3) @(negedge clk);
      rd_chk(STAT_OFS[s], 8'h00);
      chk1(irq_line, 1'b1);
      slot_partner_inst.flip(s, b);
      repeat (6) @(negedge clk);
      rd_chk(STAT_OFS[s], (b == 4) ? 8'h00 : bit_v);
      wr(STAT_OFS[s], 8'hff);
    end
    wr(EN_OFS[s], 8'h00);
    slot_partner_inst.flip(s, 0);
    repeat (6) @(negedge clk);
    rd_chk(STAT_OFS[s], 8'h01);
    chk1(irq_line, 1'b1);
    wr(STAT_OFS[s], 8'h01);
  endtask

  task automatic t_wired_or();
    wr(EN_OFS[0], 8'h01);
    wr(EN_OFS[3], 8'h01);
    slot_partner_inst.flip(0, 0);
    slot_partner_inst.flip(3, 0);
    repeat (6) @(negedge clk);
    wr(STAT_OFS[0], 8'h01);
    repeat (3) @(negedge clk);
    chk1(irq_line, 1'b0);
    wr(STAT_OFS[3], 8'h01);
    repeat (3) @(negedge clk);
    chk1(irq_line, 1'b1);
  endtask

  // --------------------------------------------------------------
  // clock, watchdog and main sequence
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #1ms;
    num_errors++;
    $display("[ERR] %0t run limit reached", $time);
    report_and_stop();
  end

  initial begin
    num_errors = 0;
    n_compared = 0;
    rstn       = 1'b0;
    reg_addr   = 5'h00;
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    reg_wdata  = 8'h00;
    fast_sel   = 1'b0;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (5) @(negedge clk);
    t_regs();
    t_ind();
    for (int s = 0; s < NUM_SLOTS; s++) t_evt(s);
    t_wired_or();
    report_and_stop();
  end
endmodule

`default_nettype wire
